/* src/sbm_params.svh */
`ifndef SBM_PARAMS_SVH
`define SBM_PARAMS_SVH

// ==========================================================
// Register offsets
`define SBM_ADDR_CONFIG 8'h00
`define SBM_ADDR_SHUNT 8'h01
`define SBM_ADDR_BUS 8'h02
`define SBM_ADDR_POWER 8'h03
`define SBM_ADDR_CURRENT 8'h04
`define SBM_ADDR_CALIB 8'h05
`define SBM_ADDR_MASK 8'h06
`define SBM_ADDR_LIMIT 8'h07

// ==========================================================
// Configuration fields
`define SBM_CFG_MODE_LSB 0
`define SBM_CFG_AVG_LSB 9
`define SBM_CFG_RESET 16'h4127
`define SBM_CFG_WMASK 16'h0fff

// ==========================================================
// Mask/enable fields
`define SBM_ME_SHUNT_OVER 15
`define SBM_ME_SHUNT_UNDER 14
`define SBM_ME_BUS_OVER 13
`define SBM_ME_BUS_UNDER 12
`define SBM_ME_POWER_OVER 11
`define SBM_ME_READY_EN 10
`define SBM_ME_AFF 4
`define SBM_ME_CONVERSION_READY_FLAG 3
`define SBM_ME_POLARITY 1
`define SBM_ME_LATCH 0
`define SBM_ME_WMASK 16'hfc03
`define SBM_ME_RESET 16'h0000

// ==========================================================
// Arithmetic scaling and timing
`define SBM_CURRENT_SHIFT 11
`define SBM_POWER_SHIFT 12
`define SBM_BUS_BITS 15
`define SBM_CLK_MHZ 250
`define SBM_PD_RECOVER_NS 40000
`define SBM_PD_RECOVER_CYC ((`SBM_PD_RECOVER_NS * `SBM_CLK_MHZ + 999) / 1000)

`endif

/* src/sbm_pkg.sv */
package sbm_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    SBM_S_PD,
    SBM_S_RECOVER,
    SBM_S_IDLE,
    SBM_S_REQ,
    SBM_S_WAIT,
    SBM_S_FINISH
  } sbm_state_t;

  // Alert function chosen by the enable bits
  typedef enum logic [2:0] {
    SBM_F_NONE,
    SBM_F_SHUNT_OVER,
    SBM_F_SHUNT_UNDER,
    SBM_F_BUS_OVER,
    SBM_F_BUS_UNDER,
    SBM_F_POWER_OVER
  } sbm_func_t;

endpackage : sbm_pkg

/* src/sbm_averager.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Sample accumulator with power-of-two averaging
module sbm_averager #(
  parameter int W = 16,
  parameter int MAX_SHIFT = 10
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic add_in,
  input wire logic signed [W-1:0] value_in,
  input wire logic [3:0] shift_in,
  output logic signed [W-1:0] avg_out
);

  localparam int AW = W + MAX_SHIFT;

  // Refuse sizes that the 4-bit shift input cannot serve
  if (W < 2 || MAX_SHIFT < 1 || MAX_SHIFT > 15) begin : g_param_check
    $error("sbm_averager: unsupported width or shift");
  end

  logic signed [AW-1:0] acc_q;
  logic signed [AW-1:0] acc_d;
  logic signed [AW-1:0] shifted_w;

  // Clear has priority; a new run never inherits old samples
  assign acc_d = clear_in ? '0 :
                 add_in ? acc_q + AW'(value_in) : acc_q;
  assign shifted_w = acc_q >>> shift_in;
  assign avg_out = shifted_w[W-1:0];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

endmodule : sbm_averager

`default_nettype wire

/* src/sbm_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbm_params.svh"

module sbm_sequencer import sbm_pkg::*; #(
  parameter int RECOVER_CYCLES = `SBM_PD_RECOVER_CYC,
  parameter int MAX_AVG_SHIFT = 10
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  output logic adc_start_out,
  output logic adc_sel_bus_out,
  output logic adc_abort_out,
  input wire logic adc_done_in,
  input wire logic [15:0] adc_data_in,
  output logic alert_out,
  output logic alert_oe_out,
  output logic busy_out
);

  // The recovery counter is 14 bits wide; longer waits need a wider one
  if (RECOVER_CYCLES < 1 || RECOVER_CYCLES > 16384 ||
      MAX_AVG_SHIFT != 10) begin : g_param_check
    $error("sbm_sequencer: unsupported parameter values");
  end

  // ========================================================
  // Helper functions

  // Averaging code to shift: 1,4,16,64,128,256,512,1024 samples
  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    case (code)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      default: avg_shift = 4'(code) + 4'h3;
    endcase
  endfunction : avg_shift

  // Both mode bits clear means power-down
  function automatic logic mode_is_pd(input logic [2:0] mode);
    mode_is_pd = (mode[1:0] == 2'h0);
  endfunction : mode_is_pd

  // ========================================================
  // Registers
  logic [15:0] cfg_q;
  logic [15:0] me_ctl_q;
  logic [15:0] limit_q;
  logic [15:0] calib_q;
  logic cal_loaded_q;
  logic [15:0] shunt_res_q;
  logic [15:0] bus_res_q;
  logic [15:0] current_res_q;
  logic [15:0] power_res_q;
  logic conversion_ready_flag_q;
  logic conversion_ready_flag_d;
  logic aff_q;
  logic aff_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  sbm_state_t state_q;
  sbm_state_t state_d;
  logic conv_bus_q;
  logic conv_bus_d;
  logic [10:0] samp_cnt_q;
  logic [10:0] samp_cnt_d;
  logic [13:0] rec_cnt_q;
  logic [13:0] rec_cnt_d;
  logic signed [15:0] cur_samp_q;

  // ========================================================
  // Register access decode
  wire cfg_wr_w = reg_wr_in && reg_addr_in == `SBM_ADDR_CONFIG;
  wire calib_wr_w = reg_wr_in && reg_addr_in == `SBM_ADDR_CALIB;
  wire me_wr_w = reg_wr_in && reg_addr_in == `SBM_ADDR_MASK;
  wire limit_wr_w = reg_wr_in && reg_addr_in == `SBM_ADDR_LIMIT;
  wire me_rd_w = reg_rd_in && reg_addr_in == `SBM_ADDR_MASK;
  wire [2:0] new_mode_w = reg_wdata_in[`SBM_CFG_MODE_LSB +: 3];
  wire new_pd_w = mode_is_pd(new_mode_w);

  // Mode fields of the live configuration
  wire [2:0] mode_w = cfg_q[`SBM_CFG_MODE_LSB +: 3];
  wire shunt_en_w = mode_w[0];
  wire bus_en_w = mode_w[1];
  wire cont_w = mode_w[2];
  wire [3:0] shift_w = avg_shift(cfg_q[`SBM_CFG_AVG_LSB +: 3]);
  wire [10:0] samp_target_w = 11'h1 << shift_w;

  // ========================================================
  // Conversion results and background arithmetic
  wire wait_w = state_q == SBM_S_WAIT;
  wire shunt_done_w = wait_w && adc_done_in && !conv_bus_q;
  wire bus_done_w = wait_w && adc_done_in && conv_bus_q;
  wire signed [15:0] shunt_samp_w = adc_data_in;
  // Bus code is unsigned, 1.25mV per count up to 40.96V
  wire [15:0] bus_samp_w = {1'b0, adc_data_in[`SBM_BUS_BITS-1:0]};
  wire signed [32:0] cur_prod_w = shunt_samp_w * $signed({1'b0, calib_q});
  wire signed [32:0] cur_scl_w = cur_prod_w >>> `SBM_CURRENT_SHIFT;
  // No calibration yet means current is held at zero
  wire signed [15:0] cur_calc_w =
    cal_loaded_q ? cur_scl_w[15:0] : 16'sh0000;
  // Power reuses the current from the latest shunt sample
  wire signed [32:0] pwr_prod_w = cur_samp_q * $signed({1'b0, bus_samp_w});
  wire signed [32:0] pwr_scl_w = pwr_prod_w >>> `SBM_POWER_SHIFT;
  wire signed [15:0] pwr_calc_w =
    cal_loaded_q ? pwr_scl_w[15:0] : 16'sh0000;

  // ========================================================
  // Averagers for shunt, bus, current and power
  wire acc_clr_w = cfg_wr_w || state_q == SBM_S_FINISH;
  wire [3:0] acc_add_w;
  wire signed [15:0] acc_val_w [4];
  wire signed [15:0] acc_avg_w [4];
  assign acc_add_w = {bus_done_w, shunt_done_w, bus_done_w, shunt_done_w};
  assign acc_val_w[0] = shunt_samp_w;
  assign acc_val_w[1] = bus_samp_w;
  assign acc_val_w[2] = cur_calc_w;
  assign acc_val_w[3] = pwr_calc_w;

  // Every conversion feeds its running sum; no output yet
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_avg
      sbm_averager #(
        .W(16),
        .MAX_SHIFT(MAX_AVG_SHIFT)
      ) u_avg (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(acc_clr_w),
        .add_in(acc_add_w[gi]),
        .value_in(acc_val_w[gi]),
        .shift_in(shift_w),
        .avg_out(acc_avg_w[gi])
      );
    end
  endgenerate

  // ========================================================
  // Conversion sequencer
  wire last_samp_w = samp_cnt_q + 11'h1 == samp_target_w;
  wire samp_end_w = bus_done_w || (shunt_done_w && !bus_en_w);

  always_comb begin
    state_d = state_q;
    conv_bus_d = conv_bus_q;
    samp_cnt_d = samp_cnt_q;
    rec_cnt_d = rec_cnt_q;
    if (cfg_wr_w) begin
      // Any non-power-down configuration write restarts, even with the same mode
      samp_cnt_d = 11'h0;
      conv_bus_d = !new_mode_w[0];
      rec_cnt_d = 14'h0;
      if (new_pd_w) begin
        state_d = SBM_S_PD;
      end else if (state_q == SBM_S_PD || state_q == SBM_S_RECOVER) begin
        state_d = SBM_S_RECOVER;
      end else begin
        state_d = SBM_S_REQ;
      end
    end else begin
      case (state_q)
        SBM_S_PD: state_d = SBM_S_PD;
        SBM_S_RECOVER: begin
          // Analog front end settles before any conversion
          rec_cnt_d = rec_cnt_q + 14'h1;
          if (rec_cnt_q == 14'(RECOVER_CYCLES - 1)) begin
            state_d = SBM_S_REQ;
          end
        end
        SBM_S_IDLE: state_d = SBM_S_IDLE;
        SBM_S_REQ: state_d = SBM_S_WAIT;
        SBM_S_WAIT: begin
          if (shunt_done_w && bus_en_w) begin
            conv_bus_d = 1'b1;
            state_d = SBM_S_REQ;
          end else if (samp_end_w) begin
            conv_bus_d = !shunt_en_w;
            if (last_samp_w) begin
              samp_cnt_d = 11'h0;
              state_d = SBM_S_FINISH;
            end else begin
              samp_cnt_d = samp_cnt_q + 11'h1;
              state_d = SBM_S_REQ;
            end
          end
        end
        SBM_S_FINISH: begin
          // Continuous modes loop, triggered modes stop after one set
          state_d = cont_w ? SBM_S_REQ : SBM_S_IDLE;
        end
        default: state_d = SBM_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= SBM_S_REQ;
      conv_bus_q <= 1'b0;
      samp_cnt_q <= 11'h0;
      rec_cnt_q <= 14'h0;
    end else begin
      state_q <= state_d;
      conv_bus_q <= conv_bus_d;
      samp_cnt_q <= samp_cnt_d;
      rec_cnt_q <= rec_cnt_d;
    end
  end

  // Request strobes toward the converter
  assign adc_start_out = state_q == SBM_S_REQ && !cfg_wr_w;
  assign adc_sel_bus_out = conv_bus_q;
  assign adc_abort_out = cfg_wr_w;
  assign busy_out = state_q == SBM_S_REQ || wait_w ||
                    state_q == SBM_S_FINISH;

  // ========================================================
  // Result registers: only written with a completed average
  wire finish_w = state_q == SBM_S_FINISH && !cfg_wr_w;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shunt_res_q <= 16'h0000;
      bus_res_q <= 16'h0000;
      current_res_q <= 16'h0000;
      power_res_q <= 16'h0000;
      cur_samp_q <= 16'sh0000;
    end else begin
      if (shunt_done_w) begin
        cur_samp_q <= cur_calc_w;
      end
      if (finish_w && shunt_en_w) begin
        shunt_res_q <= acc_avg_w[0];
        current_res_q <= acc_avg_w[2];
      end
      if (finish_w && bus_en_w) begin
        bus_res_q <= acc_avg_w[1];
        power_res_q <= acc_avg_w[3];
      end
    end
  end

  // ========================================================
  // Host-writable registers stay live in every mode
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_q <= `SBM_CFG_RESET;
      me_ctl_q <= `SBM_ME_RESET;
      limit_q <= 16'h0000;
      calib_q <= 16'h0000;
      cal_loaded_q <= 1'b0;
    end else begin
      if (cfg_wr_w) begin
        cfg_q <= reg_wdata_in & `SBM_CFG_WMASK;
      end
      if (me_wr_w) begin
        me_ctl_q <= reg_wdata_in & `SBM_ME_WMASK;
      end
      if (limit_wr_w) begin
        limit_q <= reg_wdata_in;
      end
      if (calib_wr_w) begin
        calib_q <= reg_wdata_in;
        cal_loaded_q <= 1'b1;
      end
    end
  end

  // ========================================================
  // Alert function select, highest enable bit wins
  wire [4:0] fn_en_w = me_ctl_q[`SBM_ME_SHUNT_OVER:`SBM_ME_POWER_OVER];
  sbm_func_t fn_w;
  assign fn_w = fn_en_w[4] ? SBM_F_SHUNT_OVER :
                fn_en_w[3] ? SBM_F_SHUNT_UNDER :
                fn_en_w[2] ? SBM_F_BUS_OVER :
                fn_en_w[1] ? SBM_F_BUS_UNDER :
                fn_en_w[0] ? SBM_F_POWER_OVER : SBM_F_NONE;

  // Compare at the conversion that produced the watched value
  wire signed [15:0] lim_s_w = limit_q;
  wire fn_shunt_w = fn_w == SBM_F_SHUNT_OVER || fn_w == SBM_F_SHUNT_UNDER;
  wire fn_busside_w = fn_w == SBM_F_BUS_OVER || fn_w == SBM_F_BUS_UNDER ||
                      fn_w == SBM_F_POWER_OVER;
  wire cmp_now_w = (fn_shunt_w && shunt_done_w) ||
                   (fn_busside_w && bus_done_w);
  wire hit_w = (fn_w == SBM_F_SHUNT_OVER && shunt_samp_w > lim_s_w) ||
               (fn_w == SBM_F_SHUNT_UNDER && shunt_samp_w < lim_s_w) ||
               (fn_w == SBM_F_BUS_OVER && bus_samp_w > limit_q) ||
               (fn_w == SBM_F_BUS_UNDER && bus_samp_w < limit_q) ||
               (fn_w == SBM_F_POWER_OVER && pwr_calc_w > lim_s_w);
  wire latch_w = me_ctl_q[`SBM_ME_LATCH];
  wire flag_clr_w = cfg_wr_w || me_rd_w;

  // ========================================================
  // Status flags; a set in the clearing cycle is kept
  always_comb begin
    conversion_ready_flag_d = conversion_ready_flag_q;
    if ((cfg_wr_w && !new_pd_w) || me_rd_w) begin
      conversion_ready_flag_d = 1'b0;
    end
    if (finish_w) begin
      conversion_ready_flag_d = 1'b1;
    end
    aff_d = aff_q;
    if (latch_w) begin
      if (flag_clr_w) begin
        aff_d = 1'b0;
      end
      if (cmp_now_w && hit_w) begin
        aff_d = 1'b1;
      end
    end else if (cmp_now_w) begin
      aff_d = hit_w;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conversion_ready_flag_q <= 1'b0;
      aff_q <= 1'b0;
    end else begin
      conversion_ready_flag_q <= conversion_ready_flag_d;
      aff_q <= aff_d;
    end
  end

  // ========================================================
  // Open-drain alert: drive low while the pin is at its low level
  wire alert_act_w = (aff_q && fn_w != SBM_F_NONE) ||
                     (conversion_ready_flag_q && me_ctl_q[`SBM_ME_READY_EN]);
  wire alert_pol_w = me_ctl_q[`SBM_ME_POLARITY];
  assign alert_out = 1'b0;
  assign alert_oe_out = alert_act_w ^ alert_pol_w;

  // ========================================================
  // Read data; reads change nothing but the two status flags
  wire [15:0] me_rd_val_w = me_ctl_q |
    (16'(aff_q) << `SBM_ME_AFF) | (16'(conversion_ready_flag_q) << `SBM_ME_CONVERSION_READY_FLAG);

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `SBM_ADDR_CONFIG: rdata_d = cfg_q;
        `SBM_ADDR_SHUNT: rdata_d = shunt_res_q;
        `SBM_ADDR_BUS: rdata_d = bus_res_q;
        `SBM_ADDR_POWER: rdata_d = power_res_q;
        `SBM_ADDR_CURRENT: rdata_d = current_res_q;
        `SBM_ADDR_CALIB: rdata_d = calib_q;
        `SBM_ADDR_MASK: rdata_d = me_rd_val_w;
        `SBM_ADDR_LIMIT: rdata_d = limit_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

endmodule : sbm_sequencer

`default_nettype wire

/* sim/sbm_adc_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Converter model: answers each start after LAT+1 idle cycles
module sbm_adc_model #(
  parameter int LAT = 3
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic sel_bus_in,
  input wire logic abort_in,
  input wire logic [15:0] shunt_in,
  input wire logic [15:0] bus_in,
  output logic done_out,
  output logic [15:0] data_out
);
  logic run_q;
  logic sel_q;
  logic [3:0] cnt_q;

  // Data toggles outside done so a stale value is never mistaken for fresh
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_q <= 1'b0;
      sel_q <= 1'b0;
      cnt_q <= 4'h0;
      done_out <= 1'b0;
      data_out <= 16'h0000;
    end else begin
      done_out <= 1'b0;
      data_out <= ~data_out;
      if (start_in) begin
        run_q <= 1'b1;
        sel_q <= sel_bus_in;
        cnt_q <= 4'(LAT);
      end else if (abort_in) begin
        run_q <= 1'b0;
      end else if (run_q && cnt_q == 4'h0) begin
        run_q <= 1'b0;
        done_out <= 1'b1;
        data_out <= sel_q ? bus_in : shunt_in;
      end else if (run_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : sbm_adc_model

`default_nettype wire

/* sim/sbm_sequencer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbm_params.svh"

// ==========================================================
// Port-level checker for the conversion sequencer
module sbm_seq_checker #(
  parameter int RECOVER_CYCLES = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic adc_start_out,
  input wire logic adc_sel_bus_out,
  input wire logic adc_abort_out,
  input wire logic adc_done_in,
  input wire logic alert_out,
  input wire logic alert_oe_out,
  input wire logic busy_out
);
  logic [15:0] cfg_q;
  logic [15:0] me_q;
  logic wait_q;
  int rec_q;
  // Decodes of host traffic and of the last conversion of a one-sample set
  wire cfg_wr = reg_wr_in && reg_addr_in == `SBM_ADDR_CONFIG;
  wire me_wr = reg_wr_in && reg_addr_in == `SBM_ADDR_MASK;
  wire me_rd = reg_rd_in && reg_addr_in == `SBM_ADDR_MASK;
  wire taken = adc_done_in && wait_q && !reg_wr_in;
  wire last = taken && adc_sel_bus_out == cfg_q[1] && cfg_q[11:9] == 3'h0;
  wire shot = !cfg_q[2] && cfg_q[1:0] != 2'h0;

  // Shadow registers; the recovery count starts on a wake-up write
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_q <= `SBM_CFG_RESET;
      me_q <= `SBM_ME_RESET;
      wait_q <= 1'b0;
      rec_q <= 0;
    end else begin
      if (cfg_wr) cfg_q <= reg_wdata_in & `SBM_CFG_WMASK;
      if (me_wr) me_q <= reg_wdata_in & `SBM_ME_WMASK;
      if (adc_start_out) wait_q <= 1'b1;
      else if (adc_done_in || adc_abort_out) wait_q <= 1'b0;
      if (cfg_wr && cfg_q[1:0] == 2'h0 && reg_wdata_in[1:0] != 2'h0)
        rec_q <= RECOVER_CYCLES;
      else if (rec_q != 0) rec_q <= rec_q - 1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_alert_data; alert_out == 1'b0; endproperty
  a_alert_data: assert property (p_alert_data)
    else $error("alert data line driven high");
  property p_shunt_then_bus;
    disable iff (!rst_n_in || reg_wr_in)
    taken && !adc_sel_bus_out && cfg_q[1:0] == 2'h3 |=>
      adc_start_out && adc_sel_bus_out;
  endproperty
  a_shunt_then_bus: assert property (p_shunt_then_bus)
    else $error("bus conversion did not follow shunt");
  property p_set_end;
    disable iff (!rst_n_in || reg_wr_in)
    last && cfg_q[2:0] == 3'h7 |=> !adc_start_out ##1 adc_start_out;
  endproperty
  a_set_end: assert property (p_set_end)
    else $error("continuous restart not after finish cycle");
  property p_single_shot;
    disable iff (!rst_n_in || reg_wr_in)
    last && shot |=> !adc_start_out [*8];
  endproperty
  a_single_shot: assert property (p_single_shot)
    else $error("triggered set started again");
  property p_abort; adc_abort_out == cfg_wr; endproperty
  a_abort: assert property (p_abort)
    else $error("abort not tied to configuration write");
  property p_rdata_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  property p_pd_idle; cfg_q[1:0] == 2'h0 |-> !adc_start_out && !busy_out;
  endproperty
  a_pd_idle: assert property (p_pd_idle)
    else $error("activity in power-down");
  property p_recover; rec_q != 0 |-> !adc_start_out; endproperty
  a_recover: assert property (p_recover)
    else $error("conversion during recovery");
  property p_wake; rec_q == 1 |=> ##[0:3] adc_start_out; endproperty
  a_wake: assert property (p_wake)
    else $error("no conversion after recovery");
  property p_polarity; me_q[15:10] == 6'h00 |-> alert_oe_out == me_q[1];
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("idle alert level wrong");
  property p_ready_set;
    disable iff (!rst_n_in || reg_wr_in || reg_rd_in)
    last && shot && me_q[15:10] == 6'h01 |=> ##[0:2] alert_oe_out != me_q[1];
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("ready not signalled after set");
  property p_ready_clear;
    (!busy_out [*3]) ##0 (me_rd && me_q[15:10] == 6'h01) |=>
      alert_oe_out == me_q[1];
  endproperty
  a_ready_clear: assert property (p_ready_clear)
    else $error("ready not cleared by mask read");
endmodule : sbm_seq_checker

bind sbm_sequencer sbm_seq_checker #(.RECOVER_CYCLES(RECOVER_CYCLES))
  sbm_seq_checker_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .adc_start_out(adc_start_out), .adc_sel_bus_out(adc_sel_bus_out),
  .adc_abort_out(adc_abort_out), .adc_done_in(adc_done_in),
  .alert_out(alert_out), .alert_oe_out(alert_oe_out), .busy_out(busy_out));

`default_nettype wire

/* sim/shunt_bus_monitor_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module shunt_bus_monitor_sequencer_bench;
  typedef struct {
    logic [15:0] cfg, sh, bu, cal, e_sh, e_bu, e_cu, e_pw;
  } sbm_row_t;
  // ==========================================================
  // Triggered sets: config, inputs, calibration, expected results
  sbm_row_t rows[5] = '{
    '{16'h0003, 16'h0100, 16'h2580, 16'h0, 16'h0100, 16'h2580, 16'h0, 16'h0},
    '{16'h0001, 16'hff00, 16'h1000, 16'h0, 16'hff00, 16'h2580, 16'h0, 16'h0},
    '{16'h0002, 16'h0050, 16'h9000, 16'h0, 16'hff00, 16'h1000, 16'h0, 16'h0},
    '{16'h0203, 16'h0040, 16'h0800, 16'h0800, 16'h0040, 16'h0800, 16'h0040,
      16'h0020},
    '{16'h0403, 16'h0100, 16'h2000, 16'h0800, 16'h0100, 16'h2000, 16'h0100,
      16'h0200}};
  logic [15:0] a_sh[2] = '{16'h0200, 16'h0080};
  logic [15:0] a_bu[2] = '{16'h1000, 16'h0080};
  logic [4:0] ea[2] = '{5'h15, 5'h0a};
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic [15:0] shunt_v = 16'h0000;
  logic [15:0] bus_v = 16'h0000;
  logic [15:0] reg_rdata_out, adc_data_in, rd_v;
  logic adc_start_out, adc_sel_bus_out, adc_abort_out, adc_done_in;
  logic alert_out, alert_oe_out, busy_out;
  int n_errors = 0;
  int compares = 0;

  always #2 clk_in = ~clk_in;

  sbm_sequencer #(.RECOVER_CYCLES(8)) sbm_sequencer_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .adc_start_out(adc_start_out),
    .adc_sel_bus_out(adc_sel_bus_out), .adc_abort_out(adc_abort_out),
    .adc_done_in(adc_done_in), .adc_data_in(adc_data_in),
    .alert_out(alert_out), .alert_oe_out(alert_oe_out), .busy_out(busy_out));
  sbm_adc_model sbm_adc_model_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .start_in(adc_start_out), .sel_bus_in(adc_sel_bus_out),
    .abort_in(adc_abort_out), .shunt_in(shunt_v), .bus_in(bus_v),
    .done_out(adc_done_in), .data_out(adc_data_in));

  // ==========================================================
  // Host access and comparison helpers, all driven on falling edges
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] got);
    compares++;
    if (got !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clk_in);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    rd_v = reg_rdata_out;
  endtask : rd
  // Minimum wait covers recovery, where busy may still be low
  task automatic wait_idle;
    int k;
    k = 0;
    repeat (12) @(negedge clk_in);
    while (busy_out !== 1'b0 && k < 4000) begin
      @(negedge clk_in);
      k++;
    end
    if (busy_out !== 1'b0) n_errors++;
  endtask : wait_idle
  task automatic trig;
    wr(8'h00, 16'h0003);
    wait_idle();
  endtask : trig
  task automatic wait_done(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 5000) begin
      @(negedge clk_in);
      k++;
      n = n - ((adc_done_in === 1'b1) ? 1 : 0);
    end
    if (n > 0) n_errors++;
  endtask : wait_done
  task automatic final_report;
    if (n_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // Whole run needs well under 50k cycles; this cuts a hang short
  initial begin
    #200000;
    n_errors++;
    final_report();
  end

  // ==========================================================
  // Table of triggered sets, then hand-written cases
  initial begin
    int i;
    int p;
    repeat (5) @(negedge clk_in);
    rst_n_in = 1'b1;
    for (i = 0; i < 5; i++) begin
      shunt_v = rows[i].sh;
      bus_v = rows[i].bu;
      if (rows[i].cal != 16'h0000) wr(8'h05, rows[i].cal);
      wr(8'h00, rows[i].cfg);
      wait_idle();
      rd(8'h01);
      chk("shunt", rows[i].e_sh, rd_v);
      rd(8'h02);
      chk("bus", rows[i].e_bu, rd_v);
      rd(8'h04);
      chk("current", rows[i].e_cu, rd_v);
      rd(8'h03);
      chk("power", rows[i].e_pw, rd_v);
      rd(8'h06);
      chk("ready", 16'h0008, rd_v & 16'h0008);
      rd(8'h06);
      chk("ready", 16'h0000, rd_v & 16'h0008);
    end
    shunt_v = 16'h0300;
    wr(8'h00, 16'h0403);
    repeat (3) begin
      rd(8'h01);
      chk("held shunt", 16'h0100, rd_v);
    end
    wait_idle();
    rd(8'h01);
    chk("new shunt", 16'h0300, rd_v);
    wr(8'h00, 16'h0000);
    rd(8'h06);
    chk("ready in pd", 16'h0008, rd_v & 16'h0008);
    wr(8'h07, 16'h1234);
    rd(8'h07);
    chk("limit", 16'h1234, rd_v);
    wr(8'h01, 16'hdead);
    rd(8'h01);
    chk("read only", 16'h0300, rd_v);
    rd(8'h09);
    chk("unmapped", 16'h0000, rd_v);
    shunt_v = 16'h0011;
    wr(8'h00, 16'h0001);
    wait_idle();
    rd(8'h01);
    chk("wake shunt", 16'h0011, rd_v);
    wr(8'h07, 16'h0100);
    for (p = 0; p < 2; p++) begin
      for (i = 0; i < 5; i++) begin
        shunt_v = a_sh[p];
        bus_v = a_bu[p];
        wr(8'h06, 16'h8000 >> i);
        trig();
        chk("alert", {15'h0, ea[p][4-i]}, {15'h0, alert_oe_out});
        rd(8'h06);
        chk("flag", {11'h0, ea[p][4-i], 4'h0}, rd_v & 16'h0010);
      end
    end
    wr(8'h06, 16'hc000);
    trig();
    chk("priority", 16'h0000, {15'h0, alert_oe_out});
    shunt_v = a_sh[0];
    wr(8'h06, 16'h8002);
    trig();
    chk("polarity", 16'h0000, {15'h0, alert_oe_out});
    wr(8'h06, 16'h0400);
    trig();
    chk("ready alert", 16'h0001, {15'h0, alert_oe_out});
    rd(8'h06);
    // Unlatched function flag still holds the last shunt compare result
    chk("ready source", 16'h0018, rd_v & 16'h0018);
    chk("ready alert", 16'h0000, {15'h0, alert_oe_out});
    wr(8'h06, 16'h8001);
    wr(8'h00, 16'h0007);
    wait_done(4);
    shunt_v = 16'h0080;
    wait_done(6);
    chk("latched", 16'h0001, {15'h0, alert_oe_out});
    rd(8'h06);
    chk("latched flag", 16'h0010, rd_v & 16'h0010);
    wait_done(4);
    chk("released", 16'h0000, {15'h0, alert_oe_out});
    @(negedge clk_in);
    rst_n_in = 1'b0;
    repeat (5) @(negedge clk_in);
    rst_n_in = 1'b1;
    rd(8'h00);
    chk("config reset", 16'h4127, rd_v);
    rd(8'h06);
    chk("mask reset", 16'h0000, rd_v);
    final_report();
  end
endmodule : shunt_bus_monitor_sequencer_bench

`default_nettype wire
